// File: logic/dpmca_pkg.sv
/*
 * shared constants and types of the two-port memory coherency arbiter.
 * assumes 32-bit addresses and data on both request ports.
 */
`default_nettype none

package dpmca_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    // bus interface unit data queue
    localparam int Q_DEPTH = 4;
    localparam int Q_PTR_W = 2;
    // control register on the internal bus
    localparam logic [31:0] CTRL_ADDR = 32'hFFFFE608;
    localparam int CORE_EN_BIT = 0;
    localparam logic CORE_EN_RESET = 1'b0;
    // coherency page of 1 K bytes
    localparam int PAGE_LSB = 10;
    // port numbers
    localparam logic PORT_CORE = 1'b0;
    localparam logic PORT_IB = 1'b1;

    typedef struct packed {
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } dpmca_req_type;

    typedef enum logic {
        DPMCA_IDLE = 1'b0,
        DPMCA_BUSY = 1'b1
    } dpmca_state_type;
endpackage

`default_nettype wire

// File: logic/dpmca_q_if.sv
/*
 * carrier between the arbiter and its data queue.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface dpmca_q_if;
    import dpmca_pkg::*;
    logic push_valid;
    dpmca_req_type push_data;
    logic not_full;
    logic pop_valid;
    logic pop_ready;
    dpmca_req_type pop_data;

    modport queue (
        input push_valid,
        input push_data,
        input pop_ready,
        output not_full,
        output pop_valid,
        output pop_data
    );
    modport user (
        output push_valid,
        output push_data,
        output pop_ready,
        input not_full,
        input pop_valid,
        input pop_data
    );
endinterface

`default_nettype wire

// File: logic/dpmca_queue.sv
/*
 * bus interface unit data queue for core transactions.
 * assumes one clock and a synchronous active high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module dpmca_queue (
    input wire logic CLK,
    input wire logic RST,
    dpmca_q_if.queue q
);
    import dpmca_pkg::*;

    dpmca_req_type mem_q [Q_DEPTH];
    logic [Q_PTR_W:0] wptr_ff;
    logic [Q_PTR_W:0] rptr_ff;
    logic [Q_PTR_W:0] nxt_wptr;
    logic [Q_PTR_W:0] nxt_rptr;
    logic nfull_ff;
    logic nempty_ff;
    logic do_push;
    logic do_pop;

    // refuse new entries while full [RL7]
    assign do_push = q.push_valid && nfull_ff;
    assign do_pop = q.pop_ready && nempty_ff;
    assign nxt_wptr = wptr_ff + {{Q_PTR_W{1'b0}}, do_push};
    assign nxt_rptr = rptr_ff + {{Q_PTR_W{1'b0}}, do_pop};

    always_ff @(posedge CLK) begin
        if (do_push) begin
            mem_q[wptr_ff[Q_PTR_W-1:0]] <= q.push_data;
        end
    end

    // pointers and both status bits move together from one source [RL6]
    always_ff @(posedge CLK) begin
        if (RST) begin
            wptr_ff <= '0;
            rptr_ff <= '0;
            nfull_ff <= 1'b1;
            nempty_ff <= 1'b0;
        end else begin
            wptr_ff <= nxt_wptr;
            rptr_ff <= nxt_rptr;
            nfull_ff <= !((nxt_wptr[Q_PTR_W] != nxt_rptr[Q_PTR_W]) &&
                (nxt_wptr[Q_PTR_W-1:0] == nxt_rptr[Q_PTR_W-1:0])); // [RL6]
            nempty_ff <= (nxt_wptr != nxt_rptr); // [RL6]
        end
    end

    assign q.not_full = nfull_ff;
    // head offered whenever the queue holds anything [RL7]
    assign q.pop_valid = nempty_ff;
    assign q.pop_data = mem_q[rptr_ff[Q_PTR_W-1:0]];
endmodule

`default_nettype wire

// File: logic/dpmca_top.sv
/*
 * two-port memory arbiter with read-after-write coherency per 1 K page,
 * a core transaction queue and the core-port enable control.
 * assumes core, internal bus and memory side logic share CLK.
 */
// What this block does
// RL1: accept reads from the direct core port and the internal-bus port
// RL2: before a read, finish any opposite-port write to the same 1 K page
// RL3: a write pushed ahead is issued unchanged as an ordinary write
// RL4: keep a port's request high while it still holds a pending read
// RL5: on write completion acknowledge only the port that issued it
// RL6: queue pointers and full/empty status always agree
// RL7: full queue refuses core transactions; non-empty queue keeps draining
// RL8: enable bit set to 1 turns on the direct core path
// RL9: enable resets to 0; then core traffic goes via the internal bus
// RL10: both ports requesting without dependency get alternating grants
`timescale 1ns/1ps
`default_nettype none

module dpmca_top (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CORE_VALID,
    input wire logic CORE_WR,
    input wire logic [dpmca_pkg::ADDR_W-1:0] CORE_ADDR,
    input wire logic [dpmca_pkg::DATA_W-1:0] CORE_WDATA,
    output logic CORE_READY,
    output logic CORE_RD_VALID,
    output logic [dpmca_pkg::DATA_W-1:0] CORE_RD_DATA,
    input wire logic IB_VALID,
    input wire logic IB_WR,
    input wire logic [dpmca_pkg::ADDR_W-1:0] IB_ADDR,
    input wire logic [dpmca_pkg::DATA_W-1:0] IB_WDATA,
    output logic IB_READY,
    output logic IB_RD_VALID,
    output logic [dpmca_pkg::DATA_W-1:0] IB_RD_DATA,
    output logic MEM_REQ,
    output logic MEM_WE,
    output logic [dpmca_pkg::ADDR_W-1:0] MEM_ADDR,
    output logic [dpmca_pkg::DATA_W-1:0] MEM_WDATA,
    input wire logic MEM_ACK,
    input wire logic [dpmca_pkg::DATA_W-1:0] MEM_RDATA,
    output logic CORE_PORT_ENABLE
);
    import dpmca_pkg::*;

    dpmca_q_if qif ();

    dpmca_queue u_queue (
        .CLK(CLK),
        .RST(RST),
        .q(qif.queue)
    );

    // pending slots, index 0 direct core port, index 1 internal-bus port
    logic [1:0] wr_v_ff;
    logic [1:0] rd_v_ff;
    logic [1:0] rd_core_ff;
    dpmca_req_type wr_ff [2];
    dpmca_req_type rd_ff [2];
    logic [1:0] nxt_wr_v;
    logic [1:0] nxt_rd_v;
    logic [1:0] nxt_rd_core;
    dpmca_req_type nxt_wr [2];
    dpmca_req_type nxt_rd [2];

    dpmca_state_type state_ff;
    logic core_en_ff;
    logic ib_rdy_ff;
    logic last_ff;
    logic gnt_port_ff;
    logic gnt_wr_ff;
    logic mem_req_ff;
    logic mem_we_ff;
    logic [ADDR_W-1:0] mem_addr_ff;
    logic [DATA_W-1:0] mem_wdata_ff;
    logic core_rd_v_ff;
    logic [DATA_W-1:0] core_rd_d_ff;
    logic ib_rd_v_ff;
    logic [DATA_W-1:0] ib_rd_d_ff;

    logic ib_take;
    logic ib_reg;
    logic ib_mem;
    logic q_to0;
    logic q_to1;
    logic ack_done;
    logic [1:0] port_req;
    logic issue;
    logic sel;
    logic iss_port;
    logic iss_wr;
    dpmca_req_type iss_req;
    dpmca_req_type head;

    assign head = qif.pop_data;
    assign qif.push_valid = CORE_VALID;
    assign qif.push_data = '{wr: CORE_WR, addr: CORE_ADDR, data: CORE_WDATA};
    assign ack_done = (state_ff == DPMCA_BUSY) && MEM_ACK;

    // register access decoded from internal-bus traffic [RL8]
    assign ib_take = IB_VALID && ib_rdy_ff;
    assign ib_reg = ib_take && (IB_ADDR == CTRL_ADDR); // [RL8]
    assign ib_mem = ib_take && !ib_reg; // [RL1]

    // queue head routed by the enable bit [RL8] [RL9]
    assign q_to0 = core_en_ff && qif.pop_valid &&
        (head.wr ? !wr_v_ff[PORT_CORE] : !rd_v_ff[PORT_CORE]); // [RL8]
    assign q_to1 = !core_en_ff && qif.pop_valid && !IB_VALID &&
        (head.wr ? !wr_v_ff[PORT_IB] : !rd_v_ff[PORT_IB]); // [RL9]
    assign qif.pop_ready = q_to0 || q_to1; // [RL7]

    // slot bookkeeping
    always_comb begin
        nxt_wr_v = wr_v_ff;
        nxt_rd_v = rd_v_ff;
        nxt_rd_core = rd_core_ff;
        nxt_wr = wr_ff;
        nxt_rd = rd_ff;
        // clear only the slot that was actually granted [RL5]
        if (ack_done) begin
            if (gnt_wr_ff) begin
                nxt_wr_v[gnt_port_ff] = 1'b0; // [RL5]
            end else begin
                nxt_rd_v[gnt_port_ff] = 1'b0;
            end
        end
        if (q_to0 || q_to1) begin
            if (head.wr) begin
                nxt_wr_v[q_to1] = 1'b1;
                nxt_wr[q_to1] = head;
            end else begin
                nxt_rd_v[q_to1] = 1'b1;
                nxt_rd[q_to1] = head;
                nxt_rd_core[q_to1] = 1'b1;
            end
        end
        if (ib_mem) begin
            if (IB_WR) begin
                nxt_wr_v[PORT_IB] = 1'b1;
                nxt_wr[PORT_IB] = '{wr: 1'b1, addr: IB_ADDR, data: IB_WDATA};
            end else begin
                nxt_rd_v[PORT_IB] = 1'b1; // [RL1]
                nxt_rd[PORT_IB] = '{wr: 1'b0, addr: IB_ADDR, data: IB_WDATA};
                nxt_rd_core[PORT_IB] = 1'b0;
            end
        end
    end

    // a pending read holds the port request up [RL4]
    assign port_req = wr_v_ff | rd_v_ff; // [RL4]

    // choose the next memory access
    always_comb begin
        issue = (state_ff == DPMCA_IDLE) && (port_req != 2'b00);
        sel = (port_req == 2'b11) ? !last_ff : port_req[1]; // [RL10]
        iss_port = sel;
        iss_wr = 1'b0;
        iss_req = rd_ff[sel];
        if (wr_v_ff[sel]) begin
            iss_wr = 1'b1;
            iss_req = wr_ff[sel];
        end else if (wr_v_ff[!sel] && (wr_ff[!sel].addr[ADDR_W-1:PAGE_LSB] ==
            rd_ff[sel].addr[ADDR_W-1:PAGE_LSB])) begin
            // same-page write of the other port goes first, unchanged
            iss_port = !sel; // [RL2]
            iss_wr = 1'b1;
            iss_req = wr_ff[!sel]; // [RL3]
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            wr_v_ff <= 2'b00;
            rd_v_ff <= 2'b00;
            rd_core_ff <= 2'b00;
        end else begin
            wr_v_ff <= nxt_wr_v;
            rd_v_ff <= nxt_rd_v;
            rd_core_ff <= nxt_rd_core;
        end
    end

    always_ff @(posedge CLK) begin
        wr_ff <= nxt_wr;
        rd_ff <= nxt_rd;
    end

    // internal-bus port takes a new request only with both slots free
    always_ff @(posedge CLK) begin
        if (RST) begin
            ib_rdy_ff <= 1'b0;
        end else begin
            ib_rdy_ff <= !nxt_wr_v[PORT_IB] && !nxt_rd_v[PORT_IB];
        end
    end

    // core-port enable control
    always_ff @(posedge CLK) begin
        if (RST) begin
            core_en_ff <= CORE_EN_RESET; // [RL9]
        end else if (ib_reg && IB_WR) begin
            core_en_ff <= IB_WDATA[CORE_EN_BIT]; // [RL8]
        end
    end

    // memory handshake
    always_ff @(posedge CLK) begin
        if (RST) begin
            state_ff <= DPMCA_IDLE;
            mem_req_ff <= 1'b0;
            mem_we_ff <= 1'b0;
            mem_addr_ff <= '0;
            mem_wdata_ff <= '0;
            gnt_port_ff <= 1'b0;
            gnt_wr_ff <= 1'b0;
            last_ff <= 1'b1;
        end else begin
            case (state_ff)
                DPMCA_IDLE: begin
                    if (issue) begin
                        state_ff <= DPMCA_BUSY;
                        mem_req_ff <= 1'b1;
                        mem_we_ff <= iss_wr;
                        mem_addr_ff <= iss_req.addr; // [RL3]
                        mem_wdata_ff <= iss_req.data; // [RL3]
                        gnt_port_ff <= iss_port; // [RL5]
                        gnt_wr_ff <= iss_wr;
                        last_ff <= sel; // [RL10]
                    end
                end
                DPMCA_BUSY: begin
                    if (MEM_ACK) begin
                        state_ff <= DPMCA_IDLE;
                        mem_req_ff <= 1'b0;
                    end
                end
                default: begin
                    state_ff <= DPMCA_IDLE;
                    mem_req_ff <= 1'b0;
                end
            endcase
        end
    end

    // read data return to the requester
    always_ff @(posedge CLK) begin
        if (RST) begin
            core_rd_v_ff <= 1'b0;
            core_rd_d_ff <= '0;
            ib_rd_v_ff <= 1'b0;
            ib_rd_d_ff <= '0;
        end else begin
            core_rd_v_ff <= 1'b0;
            ib_rd_v_ff <= 1'b0;
            if (ack_done && !gnt_wr_ff && rd_core_ff[gnt_port_ff]) begin
                core_rd_v_ff <= 1'b1; // [RL1]
                core_rd_d_ff <= MEM_RDATA;
            end
            // a control read never meets a memory read of this port
            if (ack_done && !gnt_wr_ff && !rd_core_ff[gnt_port_ff]) begin
                ib_rd_v_ff <= 1'b1; // [RL1]
                ib_rd_d_ff <= MEM_RDATA;
            end else if (ib_reg && !IB_WR) begin
                ib_rd_v_ff <= 1'b1;
                ib_rd_d_ff <= {{(DATA_W-1){1'b0}}, core_en_ff};
            end
        end
    end

    assign CORE_READY = qif.not_full; // [RL7]
    assign CORE_RD_VALID = core_rd_v_ff;
    assign CORE_RD_DATA = core_rd_d_ff;
    assign IB_READY = ib_rdy_ff;
    assign IB_RD_VALID = ib_rd_v_ff;
    assign IB_RD_DATA = ib_rd_d_ff;
    assign MEM_REQ = mem_req_ff;
    assign MEM_WE = mem_we_ff;
    assign MEM_ADDR = mem_addr_ff;
    assign MEM_WDATA = mem_wdata_ff;
    assign CORE_PORT_ENABLE = core_en_ff;
endmodule

`default_nettype wire

// File: test/dpmca_mem_model.sv
/* memory model on the arbiter's memory side, answering fast and slow
   in turn. assumes the arbiter's clock and reset. */
`timescale 1ns/1ps
`default_nettype none
module dpmca_mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic req,
    input wire logic we,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    output logic ack,
    output logic [31:0] rdata
);
    logic [31:0] mem [16];
    logic [2:0] cnt_ff;
    logic slow_ff;
    wire logic [3:0] idx = {addr[10], addr[4:2]};
    // data is only valid with ack; otherwise it keeps changing
    always_ff @(posedge clk) begin
        ack <= 1'b0;
        rdata <= ~rdata;
        if (rst) begin
            cnt_ff <= 3'h0;
            slow_ff <= 1'b0;
            rdata <= 32'h0;
        end else if (req && !ack) begin
            cnt_ff <= cnt_ff + 3'h1;
            if (cnt_ff == (slow_ff ? 3'h4 : 3'h0)) begin
                cnt_ff <= 3'h0;
                slow_ff <= ~slow_ff;
                ack <= 1'b1;
                rdata <= mem[idx];
                if (we) mem[idx] <= wdata;
            end
        end
    end
endmodule
`default_nettype wire

// File: test/dpmca_top_assertions.sv
/* assertions on the arbiter's top ports.
   assumes one clock and a synchronous active high reset. */
`timescale 1ns/1ps
`default_nettype none
module dpmca_top_assertions (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CORE_VALID,
    input wire logic CORE_WR,
    input wire logic CORE_READY,
    input wire logic CORE_RD_VALID,
    input wire logic IB_VALID,
    input wire logic IB_WR,
    input wire logic [dpmca_pkg::ADDR_W-1:0] IB_ADDR,
    input wire logic [dpmca_pkg::DATA_W-1:0] IB_WDATA,
    input wire logic IB_READY,
    input wire logic [dpmca_pkg::DATA_W-1:0] IB_RD_DATA,
    input wire logic IB_RD_VALID,
    input wire logic MEM_REQ,
    input wire logic MEM_WE,
    input wire logic [dpmca_pkg::ADDR_W-1:0] MEM_ADDR,
    input wire logic MEM_ACK,
    input wire logic CORE_PORT_ENABLE
);
    import dpmca_pkg::*;
    logic rd_done_ff;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    always_ff @(posedge CLK) begin
        rd_done_ff <= MEM_REQ && MEM_ACK && !MEM_WE;
    end
    sequence s_ctrl_rd;
        IB_VALID && IB_READY && !IB_WR && IB_ADDR == CTRL_ADDR;
    endsequence
    property p_rst;
        $fell(RST) |-> !CORE_PORT_ENABLE;
    endproperty
    a_rst: assert property (p_rst) else $error("enable set");
    property p_wen;
        IB_VALID && IB_READY && IB_WR && IB_ADDR == CTRL_ADDR |=>
            CORE_PORT_ENABLE == $past(IB_WDATA[CORE_EN_BIT]);
    endproperty
    a_wen: assert property (p_wen) else $error("enable write");
    property p_crd;
        s_ctrl_rd |=> IB_RD_VALID && IB_RD_DATA == {31'h0, CORE_PORT_ENABLE};
    endproperty
    a_crd: assert property (p_crd) else $error("control read");
    property p_hold;
        MEM_REQ && !MEM_ACK |=>
            MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WE);
    endproperty
    a_hold: assert property (p_hold) else $error("moved");
    property p_done;
        MEM_REQ && MEM_ACK |=> !MEM_REQ;
    endproperty
    a_done: assert property (p_done) else $error("request held");
    property p_src;
        CORE_RD_VALID |-> rd_done_ff;
    endproperty
    a_src: assert property (p_src) else $error("stray core data");
    property p_drain;
        CORE_VALID && CORE_READY && !CORE_WR |-> ##[4:400] CORE_RD_VALID;
    endproperty
    a_drain: assert property (p_drain) else $error("read lost");
    property p_ready;
        $fell(CORE_READY) |-> ##[1:400] CORE_READY;
    endproperty
    a_ready: assert property (p_ready) else $error("stuck");
endmodule
bind dpmca_top dpmca_top_assertions u_chk (.CLK, .RST, .CORE_VALID,
    .CORE_WR, .CORE_READY, .CORE_RD_VALID, .IB_VALID, .IB_WR, .IB_ADDR,
    .IB_WDATA, .IB_READY, .IB_RD_DATA, .IB_RD_VALID, .MEM_REQ, .MEM_WE,
    .MEM_ADDR, .MEM_ACK, .CORE_PORT_ENABLE);
`default_nettype wire

// File: test/tb_top.sv
/* self-checking bench: request tasks on both ports, memory model.
   assumes a 20 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dpmca_pkg::*;
    logic CLK = 1'b0, RST = 1'b1, CORE_VALID = 1'b0, IB_VALID = 1'b0;
    logic CORE_WR = 1'b0, CORE_READY, CORE_RD_VALID, IB_READY, IB_RD_VALID;
    logic MEM_REQ, MEM_WE, MEM_ACK, CORE_PORT_ENABLE;
    logic [31:0] CORE_ADDR = 32'h0, CORE_WDATA = 32'h0, CORE_RD_DATA;
    logic [31:0] IB_RD_DATA, MEM_ADDR, MEM_WDATA, MEM_RDATA;
    wire logic IB_WR = CORE_WR;
    wire logic [31:0] IB_ADDR = CORE_ADDR, IB_WDATA = CORE_WDATA;
    int n_errors = 0, cmp_count = 0, nref = 0, i, k;
    dpmca_top dut (.CLK(CLK), .RST(RST), .CORE_VALID(CORE_VALID),
        .CORE_WR(CORE_WR), .CORE_ADDR(CORE_ADDR), .CORE_WDATA(CORE_WDATA),
        .CORE_READY(CORE_READY), .CORE_RD_VALID(CORE_RD_VALID),
        .CORE_RD_DATA(CORE_RD_DATA), .IB_VALID(IB_VALID), .IB_WR(IB_WR),
        .IB_ADDR(IB_ADDR), .IB_WDATA(IB_WDATA), .IB_READY(IB_READY),
        .IB_RD_VALID(IB_RD_VALID), .IB_RD_DATA(IB_RD_DATA),
        .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR),
        .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA),
        .CORE_PORT_ENABLE(CORE_PORT_ENABLE));
    dpmca_mem_model mem (.clk(CLK), .rst(RST), .req(MEM_REQ), .we(MEM_WE),
        .addr(MEM_ADDR), .wdata(MEM_WDATA), .ack(MEM_ACK), .rdata(MEM_RDATA));
    initial begin
        forever #25 CLK = ~CLK;
    end
    always @(negedge CLK) if (CORE_VALID && CORE_READY === 1'b0) nref++;
    task automatic chk(input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic hang;
        n_errors++;
        $display("Error %0t: wait ran out", $time);
        tally_and_finish;
    endtask
    // held until ready is seen high at an edge
    task automatic req(input logic ib, wr, input logic [31:0] ad, da);
        logic r;
        CORE_VALID <= !ib;
        IB_VALID <= ib;
        CORE_WR <= wr;
        CORE_ADDR <= ad;
        CORE_WDATA <= da;
        i = 0;
        do begin
            #1;
            r = ib ? IB_READY : CORE_READY;
            @(posedge CLK);
            i++;
        end while (r !== 1'b1 && i < 300);
        if (r !== 1'b1) hang;
    endtask
    task automatic get_rd(input logic ib, input logic [31:0] exp);
        CORE_VALID <= 1'b0;
        IB_VALID <= 1'b0;
        i = 0;
        #1;
        while ((ib ? IB_RD_VALID : CORE_RD_VALID) !== 1'b1 && i < 300) begin
            @(posedge CLK);
            #1;
            i++;
        end
        if ((ib ? IB_RD_VALID : CORE_RD_VALID) !== 1'b1) hang;
        chk(ib ? IB_RD_DATA : CORE_RD_DATA, exp);
        @(posedge CLK);
    endtask
    initial begin
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        req(1'b1, 1'b0, CTRL_ADDR, 32'h0);
        get_rd(1'b1, 32'h0);
        req(1'b0, 1'b1, 32'h10, 32'h12345678);
        req(1'b0, 1'b0, 32'h10, 32'h0);
        get_rd(1'b0, 32'h12345678);
        req(1'b1, 1'b1, CTRL_ADDR, 32'h1);
        req(1'b1, 1'b0, CTRL_ADDR, 32'h0);
        get_rd(1'b1, 32'h1);
        // core read keeps memory busy while the same-page write queues
        req(1'b0, 1'b0, 32'h808, 32'h0);
        req(1'b0, 1'b1, 32'h404, 32'hA5A5C3C3);
        req(1'b1, 1'b0, 32'h404, 32'h0);
        get_rd(1'b1, 32'hA5A5C3C3);
        req(1'b0, 1'b1, 32'h408, 32'h11111111);
        req(1'b1, 1'b1, 32'h40C, 32'h22222222);
        req(1'b1, 1'b0, 32'h408, 32'h0);
        get_rd(1'b1, 32'h11111111);
        req(1'b1, 1'b0, 32'h40C, 32'h0);
        get_rd(1'b1, 32'h22222222);
        for (k = 0; k < 8; k++) begin
            req(1'b0, 1'b1, 32'(k * 4), 32'hC0DE0000 + 32'(k));
        end
        chk({31'h0, nref > 0}, 32'h1);
        req(1'b0, 1'b0, 32'h0, 32'h0);
        get_rd(1'b0, 32'hC0DE0000);
        req(1'b0, 1'b0, 32'h1C, 32'h0);
        get_rd(1'b0, 32'hC0DE0007);
        tally_and_finish;
    end
endmodule
`default_nettype wire
